//--- design/msx_pkg.sv
// package for the subtract/swap/skip/table/xor execution unit
// assumes an 8-bit core with 12-bit program address and 15-bit rom words
package msx_pkg;
  localparam int MSX_DW       = 8;
  localparam int MSX_PAW      = 12;
  localparam int MSX_ROMW     = 15;
  localparam logic [7:0] MSX_ZERO_BYTE   = 8'h00;
  localparam logic [7:0] MSX_ACC_RST     = 8'h00;
  localparam logic [7:0] MSX_LATCH_RST   = 8'h00;
  localparam logic [3:0] MSX_LAST_PAGE   = 4'hf;
  localparam logic [7:0] MSX_ONE_BYTE    = 8'h01;
  typedef enum logic [3:0] {
    MSX_OP_NONE,
    MSX_OP_SUB_ACC,
    MSX_OP_SUB_MEM,
    MSX_OP_SUB_IMM,
    MSX_OP_SWAP_MEM,
    MSX_OP_SWAP_ACC,
    MSX_OP_SKIP_ZERO,
    MSX_OP_COPY_SKIP_ZERO,
    MSX_OP_BIT_SKIP_ZERO,
    MSX_OP_TABLE_PAGED,
    MSX_OP_TABLE_LAST,
    MSX_OP_XOR_ACC,
    MSX_OP_XOR_MEM,
    MSX_OP_XOR_IMM
  } msx_op_e;
endpackage

//--- design/msx_alu.sv
// combinational adder: a + ~b + 1 with carry, nibble carry, signed range
// assumes 8-bit operands from the same clock domain
`timescale 1ns/100ps
`default_nettype none
module msx_alu
  import msx_pkg::*;
(
  input  wire logic [7:0] i_a,
  input  wire logic [7:0] i_b,
  output logic      [7:0] o_sum,
  output logic            o_carry,
  output logic            o_nibble_carry,
  output logic            o_signed_range
);
  logic [8:0] full;
  logic [4:0] low;
  logic [7:0] nb;
  assign nb = ~i_b;
  assign full = {1'b0, i_a} + {1'b0, nb} + 9'h001;
  assign low  = {1'b0, i_a[3:0]} + {1'b0, nb[3:0]} + 5'h01;
  assign o_sum          = full[7:0];
  assign o_carry        = full[8];
  assign o_nibble_carry = low[4];
  assign o_signed_range = (i_a[7] == nb[7]) && (full[7] != i_a[7]);
endmodule
`default_nettype wire

//--- design/msx_exec.sv
// execution unit for subtract, nibble swap, skip, table read and xor ops
// assumes decode presents one op per i_exec pulse, memory byte already read
// Overview of operation
// - subtract memory from accumulator into accumulator, four flags
// - subtract memory from accumulator, result written to memory
// - subtract immediate from accumulator, four flags updated
// - swap memory nibbles in place, no flags change
// - swapped memory nibbles go to accumulator, memory unchanged
// - skip next instruction when memory byte is zero
// - skip discards prefetch, adds one dummy cycle, else one cycle
// - copy memory to accumulator, skip if byte is zero
// - skip when selected memory bit is zero
// - paged table read uses page and low pointers together
// - without page option table read uses current page and low pointer
// - last-page table read uses last page and low pointer
// - xor memory into accumulator, only zero flag changes
// - xor result written to memory, only zero flag changes
// - xor immediate into accumulator, only zero flag changes
`timescale 1ns/100ps
`default_nettype none
module msx_exec
  import msx_pkg::*;
(
  input  wire logic                i_core_clk,
  input  wire logic                i_rst_n,
  input  wire logic                i_exec,
  input  wire msx_op_e             i_op,
  input  wire logic [7:0]          i_mem_data,
  input  wire logic [7:0]          i_imm,
  input  wire logic [2:0]          i_bit_sel,
  input  wire logic                i_page_opt_en,
  input  wire logic [3:0]          i_cur_page,
  input  wire logic [7:0]          i_table_low_pointer,
  input  wire logic [3:0]          i_table_page_pointer,
  input  wire logic [14:0]         i_rom_data,
  output logic [11:0]              o_rom_addr,
  output logic                     o_mem_we,
  output logic [7:0]               o_mem_wdata,
  output logic [7:0]               o_acc,
  output logic [7:0]               o_table_high_byte_latch,
  output logic                     o_zero_flag,
  output logic                     o_carry_flag,
  output logic                     o_nibble_carry_flag,
  output logic                     o_signed_range_flag,
  output logic                     o_discard_prefetch,
  output logic                     o_busy
);
  // ==========================================================
  // arithmetic
  logic [7:0] alu_b;
  logic [7:0] diff;
  logic       c_o;
  logic       nib_o;
  logic       rng_o;
  assign alu_b = (i_op == MSX_OP_SUB_IMM) ? i_imm : i_mem_data;
  msx_alu u_alu (
    .i_a            (o_acc),
    .i_b            (alu_b),
    .o_sum          (diff),
    .o_carry        (c_o),
    .o_nibble_carry (nib_o),
    .o_signed_range (rng_o)
  );
  logic [7:0] swapped;
  logic [7:0] xor_m;
  logic [7:0] xor_i;
  assign swapped = {i_mem_data[3:0], i_mem_data[7:4]};
  assign xor_m   = o_acc ^ i_mem_data;
  assign xor_i   = o_acc ^ i_imm;
  // ==========================================================
  // skip decision
  logic skip_hit;
  always_comb begin
    skip_hit = 1'b0;
    case (i_op)
      MSX_OP_SKIP_ZERO:      skip_hit = (i_mem_data == MSX_ZERO_BYTE);
      MSX_OP_COPY_SKIP_ZERO: skip_hit = (i_mem_data == MSX_ZERO_BYTE);
      MSX_OP_BIT_SKIP_ZERO:  skip_hit = ~i_mem_data[i_bit_sel];
      default:               skip_hit = 1'b0;
    endcase
  end
  // ==========================================================
  // rom address for table reads, combinational for same-cycle fetch
  always_comb begin
    case (i_op)
      MSX_OP_TABLE_PAGED:
        o_rom_addr = i_page_opt_en ? {i_table_page_pointer,
                                      i_table_low_pointer}
                                   : {i_cur_page, i_table_low_pointer};
      MSX_OP_TABLE_LAST: o_rom_addr = {MSX_LAST_PAGE, i_table_low_pointer};
      default:           o_rom_addr = {i_cur_page, i_table_low_pointer};
    endcase
  end
  logic is_table;
  assign is_table = (i_op == MSX_OP_TABLE_PAGED) ||
                    (i_op == MSX_OP_TABLE_LAST);
  // ==========================================================
  // accumulator
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_acc <= MSX_ACC_RST;
    end else if (i_exec && !o_busy) begin
      case (i_op)
        MSX_OP_SUB_ACC:        o_acc <= diff;
        MSX_OP_SUB_IMM:        o_acc <= diff;
        MSX_OP_SWAP_ACC:       o_acc <= swapped;
        MSX_OP_COPY_SKIP_ZERO: o_acc <= i_mem_data;
        MSX_OP_XOR_ACC:        o_acc <= xor_m;
        MSX_OP_XOR_IMM:        o_acc <= xor_i;
        default:               o_acc <= o_acc;
      endcase
    end
  end
  // ==========================================================
  // memory write-back, one cycle after the exec pulse
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_mem_we    <= 1'b0;
      o_mem_wdata <= MSX_ZERO_BYTE;
    end else begin
      o_mem_we <= 1'b0;
      if (i_exec && !o_busy) begin
        case (i_op)
          MSX_OP_SUB_MEM: begin
            o_mem_we    <= 1'b1;
            o_mem_wdata <= diff;
          end
          MSX_OP_SWAP_MEM: begin
            o_mem_we    <= 1'b1;
            o_mem_wdata <= swapped;
          end
          MSX_OP_XOR_MEM: begin
            o_mem_we    <= 1'b1;
            o_mem_wdata <= xor_m;
          end
          MSX_OP_TABLE_PAGED, MSX_OP_TABLE_LAST: begin
            o_mem_we    <= 1'b1;
            o_mem_wdata <= i_rom_data[7:0];
          end
          default: begin
            o_mem_we    <= 1'b0;
          end
        endcase
      end
    end
  end
  // ==========================================================
  // table high byte latch
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_table_high_byte_latch <= MSX_LATCH_RST;
    end else if (i_exec && !o_busy && is_table) begin
      // high part is only seven bits of the 15-bit word
      o_table_high_byte_latch <= {1'b0, i_rom_data[14:8]};
    end
  end
  // ==========================================================
  // flags
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_zero_flag         <= 1'b0;
      o_carry_flag        <= 1'b0;
      o_nibble_carry_flag <= 1'b0;
      o_signed_range_flag <= 1'b0;
    end else if (i_exec && !o_busy) begin
      case (i_op)
        MSX_OP_SUB_ACC, MSX_OP_SUB_MEM, MSX_OP_SUB_IMM: begin
          o_zero_flag         <= (diff == MSX_ZERO_BYTE);
          o_carry_flag        <= c_o;
          o_nibble_carry_flag <= nib_o;
          o_signed_range_flag <= rng_o;
        end
        MSX_OP_XOR_ACC, MSX_OP_XOR_MEM: begin
          o_zero_flag <= (xor_m == MSX_ZERO_BYTE);
        end
        MSX_OP_XOR_IMM: begin
          o_zero_flag <= (xor_i == MSX_ZERO_BYTE);
        end
        default: begin
          o_zero_flag <= o_zero_flag;
        end
      endcase
    end
  end
  // ==========================================================
  // skip: dummy cycle; exec pulses during it are ignored
  // discard and dummy cycle
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_busy <= 1'b0;
    end else begin
      o_busy <= i_exec && !o_busy && skip_hit;
    end
  end
  assign o_discard_prefetch = o_busy;
  // ==========================================================
  // checks
  property p_skip_dummy;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      (i_exec && !o_busy && skip_hit) |=> o_busy ##1 !o_busy;
  endproperty
  a_skip_dummy: assert property (p_skip_dummy)
    else $error("skip did not give one dummy cycle");
  property p_no_skip;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      (i_exec && !o_busy && !skip_hit) |=> !o_busy;
  endproperty
  a_no_skip: assert property (p_no_skip)
    else $error("dummy cycle without skip");
  property p_zero_skip;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      (i_exec && !o_busy && i_op == MSX_OP_SKIP_ZERO &&
       i_mem_data == MSX_ZERO_BYTE) |=> o_discard_prefetch;
  endproperty
  a_zero_skip: assert property (p_zero_skip)
    else $error("zero byte not skipped");
  property p_bit;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      (i_exec && !o_busy && i_op == MSX_OP_BIT_SKIP_ZERO)
        |=> (o_busy == !$past(i_mem_data[i_bit_sel]));
  endproperty
  a_bit: assert property (p_bit)
    else $error("bit skip wrong");
  property p_sub_acc;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      (i_exec && !o_busy && i_op == MSX_OP_SUB_ACC)
        |=> (o_acc == 8'($past(o_acc) - $past(i_mem_data)))
            && (o_carry_flag == ($past(o_acc) >= $past(i_mem_data)));
  endproperty
  a_sub_acc: assert property (p_sub_acc)
    else $error("subtract to acc wrong");
  property p_sub_mem;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      (i_exec && !o_busy && i_op == MSX_OP_SUB_MEM)
        |=> o_mem_we && (o_mem_wdata == 8'($past(o_acc) - $past(i_mem_data)))
            && $stable(o_acc);
  endproperty
  a_sub_mem: assert property (p_sub_mem)
    else $error("subtract to memory wrong");
  property p_swap_mem;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      (i_exec && !o_busy && i_op == MSX_OP_SWAP_MEM)
        |=> o_mem_we
            && (o_mem_wdata == {$past(i_mem_data[3:0]),
                                $past(i_mem_data[7:4])})
            && $stable(o_zero_flag) && $stable(o_carry_flag)
            && $stable(o_nibble_carry_flag) && $stable(o_signed_range_flag);
  endproperty
  a_swap_mem: assert property (p_swap_mem)
    else $error("swap in place wrong");
  property p_xor_imm;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      (i_exec && !o_busy && i_op == MSX_OP_XOR_IMM)
        |=> (o_zero_flag == (o_acc == MSX_ZERO_BYTE)) && $stable(o_carry_flag);
  endproperty
  a_xor_imm: assert property (p_xor_imm)
    else $error("xor immediate flag wrong");
  property p_last;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      (i_op == MSX_OP_TABLE_LAST) |-> o_rom_addr[11:8] == MSX_LAST_PAGE;
  endproperty
  a_last: assert property (p_last)
    else $error("last page address wrong");
  c_skip: cover property (@(posedge i_core_clk) o_busy);
  c_sub:  cover property (@(posedge i_core_clk)
    i_exec && i_op == MSX_OP_SUB_MEM);
  c_tab:  cover property (@(posedge i_core_clk)
    i_exec && i_op == MSX_OP_TABLE_PAGED && i_page_opt_en);
endmodule
`default_nettype wire

//--- dv/tb_msx_exec.sv
// self-checking bench for the subtract/swap/skip/table/xor execution unit
// assumes msx_pkg compiled first; rom and memory bytes driven by the bench
`timescale 1ns/100ps
`default_nettype none
module tb_mcu_subtract_swap_skip_table_xor_exec
  import msx_pkg::*;
;
  // ==========================================================
  // signals
  logic        i_core_clk = 1'b0;
  logic        i_rst_n = 1'b0;
  logic        i_exec = 1'b0;
  msx_op_e     i_op = MSX_OP_NONE;
  logic [7:0]  i_mem_data = 8'h00;
  logic [7:0]  i_imm = 8'h00;
  logic [2:0]  i_bit_sel = 3'h0;
  logic        i_page_opt_en = 1'b0;
  logic [3:0]  i_cur_page = 4'h0;
  logic [7:0]  i_table_low_pointer = 8'h00;
  logic [3:0]  i_table_page_pointer = 4'h0;
  logic [14:0] i_rom_data = 15'h0000;
  logic [11:0] o_rom_addr;
  logic        o_mem_we, o_zero_flag, o_carry_flag;
  logic [7:0]  o_mem_wdata, o_acc, o_table_high_byte_latch;
  logic        o_nibble_carry_flag, o_signed_range_flag;
  logic        o_discard_prefetch, o_busy;
  int          err_count = 0;
  int          cmp_count = 0;
  int          seed = 32'h7fa8;
  // model state, reset values are zero
  logic [7:0]  acc = 8'h00;
  logic [7:0]  lat = 8'h00;
  logic        zf = 1'b0, cf = 1'b0, ncf = 1'b0, ovf = 1'b0;

  always #10 i_core_clk = ~i_core_clk;

  msx_exec dut (
    .i_core_clk              (i_core_clk),
    .i_rst_n                 (i_rst_n),
    .i_exec                  (i_exec),
    .i_op                    (i_op),
    .i_mem_data              (i_mem_data),
    .i_imm                   (i_imm),
    .i_bit_sel               (i_bit_sel),
    .i_page_opt_en           (i_page_opt_en),
    .i_cur_page              (i_cur_page),
    .i_table_low_pointer     (i_table_low_pointer),
    .i_table_page_pointer    (i_table_page_pointer),
    .i_rom_data              (i_rom_data),
    .o_rom_addr              (o_rom_addr),
    .o_mem_we                (o_mem_we),
    .o_mem_wdata             (o_mem_wdata),
    .o_acc                   (o_acc),
    .o_table_high_byte_latch (o_table_high_byte_latch),
    .o_zero_flag             (o_zero_flag),
    .o_carry_flag            (o_carry_flag),
    .o_nibble_carry_flag     (o_nibble_carry_flag),
    .o_signed_range_flag     (o_signed_range_flag),
    .o_discard_prefetch      (o_discard_prefetch),
    .o_busy                  (o_busy)
  );

  // ==========================================================
  // compare and close
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("FAIL t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic close_out;
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // ==========================================================
  // one operation: drive, model, compare
  task automatic do_op(input int k);
    msx_op_e     op;
    logic [7:0]  m, im, r, sw, nacc, wd, x;
    logic [2:0]  bs;
    logic [14:0] rom;
    logic [8:0]  s9;
    logic [4:0]  s5;
    logic        we, sk;
    op = msx_op_e'(k);
    m = (($random(seed) & 3) == 0) ? 8'h00 : 8'($random(seed));
    im = 8'($random(seed));
    bs = 3'($random(seed));
    rom = 15'($random(seed));
    @(posedge i_core_clk);
    i_exec <= 1'b1;
    i_op <= op;
    i_mem_data <= m;
    i_imm <= im;
    i_bit_sel <= bs;
    i_rom_data <= rom;
    i_page_opt_en <= 1'($random(seed));
    i_cur_page <= 4'($random(seed));
    i_table_low_pointer <= 8'($random(seed));
    i_table_page_pointer <= 4'($random(seed));
    #1;
    if (op == MSX_OP_TABLE_LAST)
      check(16'(o_rom_addr), {4'h0, MSX_LAST_PAGE, i_table_low_pointer});
    if (op == MSX_OP_TABLE_PAGED)
      check(16'(o_rom_addr), {4'h0, i_page_opt_en ? i_table_page_pointer
            : i_cur_page, i_table_low_pointer});
    r = ~((op == MSX_OP_SUB_IMM) ? im : m);
    s9 = {1'b0, acc} + {1'b0, r} + 9'h001;
    s5 = {1'b0, acc[3:0]} + {1'b0, r[3:0]} + 5'h01;
    sw = {m[3:0], m[7:4]};
    x = acc ^ ((op == MSX_OP_XOR_IMM) ? im : m);
    nacc = acc;
    wd = 8'h00;
    we = 1'b0;
    case (op)
      MSX_OP_SUB_ACC, MSX_OP_SUB_IMM: nacc = s9[7:0];
      MSX_OP_SWAP_ACC: nacc = sw;
      MSX_OP_COPY_SKIP_ZERO: nacc = m;
      MSX_OP_XOR_ACC, MSX_OP_XOR_IMM: nacc = x;
      MSX_OP_SUB_MEM: wd = s9[7:0];
      MSX_OP_SWAP_MEM: wd = sw;
      MSX_OP_XOR_MEM: wd = x;
      MSX_OP_TABLE_PAGED, MSX_OP_TABLE_LAST: begin
        wd = rom[7:0];
        lat = {1'b0, rom[14:8]};
      end
      default: ;
    endcase
    we = op inside {MSX_OP_SUB_MEM, MSX_OP_SWAP_MEM, MSX_OP_XOR_MEM,
                    MSX_OP_TABLE_PAGED, MSX_OP_TABLE_LAST};
    if (op inside {MSX_OP_SUB_ACC, MSX_OP_SUB_MEM, MSX_OP_SUB_IMM}) begin
      cf = s9[8];
      ncf = s5[4];
      ovf = (acc[7] == r[7]) && (s9[7] != acc[7]);
      zf = (s9[7:0] == 8'h00);
    end
    if (op inside {MSX_OP_XOR_ACC, MSX_OP_XOR_MEM, MSX_OP_XOR_IMM})
      zf = (x == 8'h00);
    sk = ((op inside {MSX_OP_SKIP_ZERO, MSX_OP_COPY_SKIP_ZERO}) && m == 8'h00)
         || (op == MSX_OP_BIT_SKIP_ZERO && !m[bs]);
    acc = nacc;
    @(posedge i_core_clk);
    i_exec <= sk;
    i_op <= MSX_OP_XOR_IMM;
    i_imm <= 8'hff;
    #1;
    check(16'(o_acc), 16'(acc));
    check(16'(o_mem_we), 16'(we));
    if (we)
      check(16'(o_mem_wdata), 16'(wd));
    check(16'(o_table_high_byte_latch), 16'(lat));
    check(16'(o_zero_flag), 16'(zf));
    check(16'(o_carry_flag), 16'(cf));
    check(16'(o_nibble_carry_flag), 16'(ncf));
    check(16'(o_signed_range_flag), 16'(ovf));
    check(16'(o_busy), 16'(sk));
    check(16'(o_discard_prefetch), 16'(sk));
    // exec offered in the dummy cycle must be dropped
    if (sk) begin
      @(posedge i_core_clk);
      i_exec <= 1'b0;
      #1;
      check(16'(o_busy), 16'h0000);
      check(16'(o_acc), 16'(acc));
      check(16'(o_zero_flag), 16'(zf));
    end
  endtask

  // ==========================================================
  // main sequence and watchdog
  initial begin
    repeat (8) @(posedge i_core_clk);
    check(16'(o_acc), 16'(MSX_ACC_RST));
    check(16'({o_busy, o_mem_we, o_zero_flag, o_carry_flag}), 16'h0000);
    i_rst_n <= 1'b1;
    for (int k = 0; k < 14; k++)
      do_op(k);
    repeat (600)
      do_op(1 + ($unsigned($random(seed)) % 13));
    close_out;
  end

  initial begin
    repeat (10000) @(posedge i_core_clk);
    err_count++;
    close_out;
  end
endmodule
`default_nettype wire
